// ==== hdl/syscr_top.sv ====
// Purpose: System control register: baud code, channel B enable, channel gains
// Assumes: Host port logic delivers one-cycle read/write strobes on i_core_clk
// Notes:   Register answers one cycle after a read strobe; other addresses read 0
//
// Contract
// - Register at 0x00, resets to 0x0003
// - Bits 14..8 read strap-derived baud code
// - Straps 00 give 0x2E, 01 give 0x16
// - Straps 10 give 0x0B, 11 give 0x05
// - Baud code reads zero with SPI selected
// - Baud code included in register checksum
// - Bit 6 enables channel B, else zero
// - Bits 5..4: channel B gain 1,2,4,4
// - Bits 3..2: voltage gain 1,2,4,4
// - Bits 1..0: channel A gain 1,2,8,16
`timescale 1ns/10ps
module syscr_top
  import syscr_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // Host register port
  input  wire syscr_req_s  i_reg_req,
  output logic [15:0]      o_reg_rdata,
  output logic             o_reg_rvalid,
  // Strap pins and interface select
  input  wire logic        i_baud_strap_high,
  input  wire logic        i_baud_strap_low,
  input  wire logic        i_spi_selected,
  // Channel B sample path
  input  wire logic [23:0] i_adc_b_sample,
  output logic [23:0]      o_adc_b_sample,
  // Analog controls
  output logic             o_second_current_adc_on,
  output logic [1:0]       o_current_b_gain,
  output logic [1:0]       o_voltage_gain,
  output logic [1:0]       o_current_a_gain,
  output logic [4:0]       o_current_b_factor,
  output logic [4:0]       o_voltage_factor,
  output logic [4:0]       o_current_a_factor,
  // Checksum feed and full register image
  output logic [15:0]      o_checksum_word,
  output logic [15:0]      o_system_control
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  syscr_state_s state_r;     // All block state
  syscr_state_s state_nxt;   // Next value of the state
  logic [6:0]   baud_map;    // Live strap lookup
  logic [15:0]  image;       // Current register image
  logic         hit;         // Request addresses this register

  ////////////////////////////////////////////////////////////////////////////
  // Strap lookup
  syscr_baud_map u_baud_map
  (
    .i_baud_strap_high (i_baud_strap_high),
    .i_baud_strap_low  (i_baud_strap_low),
    .i_spi_selected    (i_spi_selected),
    .o_baud_code       (baud_map)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register image assembly; reserved bits always read zero
  always_comb
  begin
    image                                   = SYSCR_READ_ZERO;
    image[SYSCR_BAUD_MSB:SYSCR_BAUD_LSB]    = state_r.baud;
    image[SYSCR_BIT_ADC_B_ON]               = state_r.ctrl.adc_b_on;
    image[SYSCR_GAIN_B_MSB:SYSCR_GAIN_B_LSB] = state_r.ctrl.gain_b;
    image[SYSCR_GAIN_U_MSB:SYSCR_GAIN_U_LSB] = state_r.ctrl.gain_u;
    image[SYSCR_GAIN_A_MSB:SYSCR_GAIN_A_LSB] = state_r.ctrl.gain_a;
  end

  assign hit = (i_reg_req.addr == SYSCR_ADDR_SYSTEM_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    state_nxt        = state_r;
    state_nxt.rvalid = i_reg_req.rd;
    state_nxt.baud   = baud_map;
    // Read answer; unmapped addresses answer zero
    if (i_reg_req.rd)
    begin
      state_nxt.rdata = hit ? image : SYSCR_READ_ZERO;
    end
    if (i_reg_req.wr && hit)
    begin
      // Reserved bits 15 and 7 are not stored, so a stray one cannot stick
      state_nxt.ctrl.adc_b_on = i_reg_req.wdata[SYSCR_BIT_ADC_B_ON];
      state_nxt.ctrl.gain_b   = i_reg_req.wdata[SYSCR_GAIN_B_MSB:SYSCR_GAIN_B_LSB];
      state_nxt.ctrl.gain_u   = i_reg_req.wdata[SYSCR_GAIN_U_MSB:SYSCR_GAIN_U_LSB];
      state_nxt.ctrl.gain_a   = i_reg_req.wdata[SYSCR_GAIN_A_MSB:SYSCR_GAIN_A_LSB];
    end
    // channel B gated to zero when off
    state_nxt.adc_b = state_r.ctrl.adc_b_on ? i_adc_b_sample : SYSCR_SAMPLE_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      state_r.ctrl.adc_b_on <= SYSCR_RST_ADC_B_ON;
      state_r.ctrl.gain_b   <= SYSCR_RST_GAIN_B;
      state_r.ctrl.gain_u   <= SYSCR_RST_GAIN_U;
      state_r.ctrl.gain_a   <= SYSCR_RST_GAIN_A;
      state_r.baud          <= SYSCR_RST_BAUD;
      state_r.rdata         <= SYSCR_READ_ZERO;
      state_r.rvalid        <= 1'h0;
      state_r.adc_b         <= SYSCR_SAMPLE_ZERO;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain decode; codes 10 and 11 both mean x4 on channel B and voltage
  always_comb
  begin
    case (state_r.ctrl.gain_b)
      2'h0:    o_current_b_factor = SYSCR_GAIN_X1;
      2'h1:    o_current_b_factor = SYSCR_GAIN_X2;
      default: o_current_b_factor = SYSCR_GAIN_X4;
    endcase
    case (state_r.ctrl.gain_u)
      2'h0:    o_voltage_factor = SYSCR_GAIN_X1;
      2'h1:    o_voltage_factor = SYSCR_GAIN_X2;
      default: o_voltage_factor = SYSCR_GAIN_X4;
    endcase
    case (state_r.ctrl.gain_a)
      2'h0:    o_current_a_factor = SYSCR_GAIN_X1;
      2'h1:    o_current_a_factor = SYSCR_GAIN_X2;
      2'h2:    o_current_a_factor = SYSCR_GAIN_X8;
      default: o_current_a_factor = SYSCR_GAIN_X16;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_reg_rdata             = state_r.rdata;
  assign o_reg_rvalid            = state_r.rvalid;
  assign o_adc_b_sample          = state_r.adc_b;
  assign o_second_current_adc_on = state_r.ctrl.adc_b_on;
  assign o_current_b_gain        = state_r.ctrl.gain_b;
  assign o_voltage_gain          = state_r.ctrl.gain_u;
  assign o_current_a_gain        = state_r.ctrl.gain_a;
  assign o_system_control        = image;
  assign o_checksum_word         = image;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_reset_image: assert property (@(posedge i_core_clk)
    $past(i_reset) |-> (o_system_control == SYSCR_RESET_VALUE))
    else $error("Register image wrong after reset");

  a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_system_control[SYSCR_BIT_RSVD_HIGH] == 1'h0) && (o_system_control[SYSCR_BIT_RSVD_LOW] == 1'h0))
    else $error("Reserved bit reads one");

  a_baud_follows: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $fell(i_baud_strap_low) && !i_spi_selected && $stable(i_spi_selected) && $stable(i_baud_strap_high)
    |=> $changed(o_system_control[SYSCR_BAUD_MSB:SYSCR_BAUD_LSB]))
    else $error("Baud code did not follow straps");

  a_baud_low_codes: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!i_spi_selected && !i_baud_strap_high)
    |=> (o_checksum_word[SYSCR_BAUD_MSB:SYSCR_BAUD_LSB] == ($past(i_baud_strap_low) ? 7'h16 : 7'h2E)))
    else $error("Baud code for straps 0x wrong");

  a_baud_high_codes: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!i_spi_selected && i_baud_strap_high)
    |=> (o_checksum_word[SYSCR_BAUD_MSB:SYSCR_BAUD_LSB] == ($past(i_baud_strap_low) ? 7'h05 : 7'h0B)))
    else $error("Baud code for straps 1x wrong");

  a_spi_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_spi_selected |=> (o_system_control[SYSCR_BAUD_MSB:SYSCR_BAUD_LSB] == 7'h00))
    else $error("Baud code not zero under SPI");

  a_adc_b_gate: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_second_current_adc_on && $stable(o_second_current_adc_on)) ##1 !o_second_current_adc_on [*2]
    |-> (o_adc_b_sample == 24'h000000))
    else $error("Channel B sample not forced to zero");

  a_gain_b_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_reg_req.wr && hit && (i_reg_req.wdata[5:4] == 2'h3)) |=> (o_current_b_factor == 5'h04))
    else $error("Channel B gain 11 not x4");

  a_gain_u_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_reg_req.wr && hit && (i_reg_req.wdata[3:2] == 2'h2)) |=> (o_voltage_factor == 5'h04))
    else $error("Voltage gain 10 not x4");

  a_gain_a_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_reg_req.wr && hit && (i_reg_req.wdata[1:0] == 2'h2)) |=> (o_current_a_factor == 5'h08))
    else $error("Channel A gain 10 not x8");

  a_baud_write_ignored: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_reg_req.wr && hit && (i_reg_req.wdata[14:8] == 7'h7F)) |=> (o_system_control[14:8] != 7'h7F))
    else $error("Write reached the baud code field");

  a_read_answer: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_reg_req.rd && hit && !i_reg_req.wr) |=> (o_reg_rvalid && (o_reg_rdata == $past(o_checksum_word))))
    else $error("Read answer differs from image");

  // A host polling other addresses must still get an answer, or its port logic would hang
  a_unmapped_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_reg_req.rd && !hit) |=> (o_reg_rvalid && (o_reg_rdata == SYSCR_READ_ZERO)))
    else $error("Unmapped read did not answer zero");

  // The answer strobe stands one cycle only, never without a read behind it
  a_rvalid_pulse: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i_reg_req.rd |=> !o_reg_rvalid)
    else $error("Read answer strobe without a read");

endmodule

// ==== hdl/syscr_pkg.sv ====
// Purpose: Shared constants and types for the system control register block
// Assumes: One 200 MHz core clock, synchronous active-high reset
// Notes:   Field positions, reset values and gain codes live here only
package syscr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [6:0]  SYSCR_ADDR_SYSTEM_CONTROL = 7'h00;  // Only register here
  localparam logic [15:0] SYSCR_RESET_VALUE         = 16'h0003;
  localparam logic [15:0] SYSCR_READ_ZERO           = 16'h0000;

  // Field positions
  localparam int SYSCR_BIT_RSVD_HIGH  = 15;
  localparam int SYSCR_BAUD_MSB       = 14;
  localparam int SYSCR_BAUD_LSB       = 8;
  localparam int SYSCR_BIT_RSVD_LOW   = 7;
  localparam int SYSCR_BIT_ADC_B_ON   = 6;
  localparam int SYSCR_GAIN_B_MSB     = 5;
  localparam int SYSCR_GAIN_B_LSB     = 4;
  localparam int SYSCR_GAIN_U_MSB     = 3;
  localparam int SYSCR_GAIN_U_LSB     = 2;
  localparam int SYSCR_GAIN_A_MSB     = 1;
  localparam int SYSCR_GAIN_A_LSB     = 0;

  // Field reset values
  localparam logic       SYSCR_RST_ADC_B_ON = 1'h0;
  localparam logic [1:0] SYSCR_RST_GAIN_B   = 2'h0;
  localparam logic [1:0] SYSCR_RST_GAIN_U   = 2'h0;
  localparam logic [1:0] SYSCR_RST_GAIN_A   = 2'h3;
  localparam logic [6:0] SYSCR_RST_BAUD     = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Baud codes per strap setting
  localparam logic [6:0] SYSCR_BAUD_2400  = 7'h2E;
  localparam logic [6:0] SYSCR_BAUD_4800  = 7'h16;
  localparam logic [6:0] SYSCR_BAUD_9600  = 7'h0B;
  localparam logic [6:0] SYSCR_BAUD_19200 = 7'h05;
  localparam logic [6:0] SYSCR_BAUD_NONE  = 7'h00;

  // Gain factors as plain multipliers
  localparam logic [4:0] SYSCR_GAIN_X1  = 5'h01;
  localparam logic [4:0] SYSCR_GAIN_X2  = 5'h02;
  localparam logic [4:0] SYSCR_GAIN_X4  = 5'h04;
  localparam logic [4:0] SYSCR_GAIN_X8  = 5'h08;
  localparam logic [4:0] SYSCR_GAIN_X16 = 5'h10;

  localparam logic [23:0] SYSCR_SAMPLE_ZERO = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic        wr;     // One-cycle write strobe
    logic        rd;     // One-cycle read strobe
    logic [6:0]  addr;   // Register address
    logic [15:0] wdata;  // Write data
  } syscr_req_s;

  typedef struct packed {
    logic       adc_b_on;
    logic [1:0] gain_b;
    logic [1:0] gain_u;
    logic [1:0] gain_a;
  } syscr_ctrl_s;

  typedef struct packed {
    syscr_ctrl_s ctrl;    // Host-writable fields
    logic [6:0]  baud;    // Strap-derived code
    logic [15:0] rdata;   // Read answer
    logic        rvalid;  // Read answer strobe
    logic [23:0] adc_b;   // Gated channel B sample
  } syscr_state_s;

endpackage

// ==== hdl/syscr_baud_map.sv ====
// Purpose: Map the two baud strap pins to the read-only baud code
// Assumes: Straps and interface select are steady, synchronous levels
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/10ps
module syscr_baud_map
  import syscr_pkg::*;
(
  // Strap inputs
  input  wire logic       i_baud_strap_high,
  input  wire logic       i_baud_strap_low,
  input  wire logic       i_spi_selected,
  // Code out
  output logic [6:0]      o_baud_code
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap lookup, forced to zero when the serial host port is SPI
  always_comb
  begin
    if (i_spi_selected)
    begin
      // Code is meaningless without the UART, so it reads zero
      o_baud_code = SYSCR_BAUD_NONE;
    end
    else
    begin
      case ({i_baud_strap_high, i_baud_strap_low})
        2'h0:    o_baud_code = SYSCR_BAUD_2400;
        2'h1:    o_baud_code = SYSCR_BAUD_4800;
        2'h2:    o_baud_code = SYSCR_BAUD_9600;
        default: o_baud_code = SYSCR_BAUD_19200;
      endcase
    end
  end

endmodule

// ==== bench/syscr_bench.sv ====
// Purpose: Self-checking bench for the system control register block
// Assumes: Inputs change on the falling edge; outputs are sampled on the falling edge
// Notes:   Expectations come from literal tables, never from the design's outputs
`timescale 1ns/10ps
// Compare one value with case equality and count it
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module syscr_bench;
  import syscr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic        i_core_clk;    // 200 MHz clock
  logic        i_reset;       // Synchronous reset
  syscr_req_s  req;           // Host request
  logic [15:0] rdata;         // Read answer
  logic        rvalid;        // Read strobe
  logic        strap_h;       // Baud strap, high pin
  logic        strap_l;       // Baud strap, low pin
  logic        spi;           // Host interface is SPI
  logic [23:0] smp_in;        // Raw channel B sample
  logic [23:0] smp_out;       // Gated channel B sample
  logic        adc_on;        // Channel B enable
  logic [1:0]  gb, gu, ga;    // Raw gain fields
  logic [4:0]  fb, fu, fa;    // Decoded gain factors
  logic [15:0] csum;          // Checksum feed
  logic [15:0] image;         // Register image
  logic [15:0] seen;          // Read data held by the access task
  logic        seen_v;        // Read strobe held by the access task
  logic [15:0] wd;            // Write word under test
  int          err_total;     // Mismatches
  int          checks_done;   // Comparisons
  // Baud codes indexed by {high, low} strap value
  logic [6:0]  codes [4] = '{7'h2E, 7'h16, 7'h0B, 7'h05};

  syscr_top i_dut (
    .i_core_clk              (i_core_clk),
    .i_reset                 (i_reset),
    .i_reg_req               (req),
    .o_reg_rdata             (rdata),
    .o_reg_rvalid            (rvalid),
    .i_baud_strap_high       (strap_h),
    .i_baud_strap_low        (strap_l),
    .i_spi_selected          (spi),
    .i_adc_b_sample          (smp_in),
    .o_adc_b_sample          (smp_out),
    .o_second_current_adc_on (adc_on),
    .o_current_b_gain        (gb),
    .o_voltage_gain          (gu),
    .o_current_a_gain        (ga),
    .o_current_b_factor      (fb),
    .o_voltage_factor        (fu),
    .o_current_a_factor      (fa),
    .o_checksum_word         (csum),
    .o_system_control        (image)
  );

  // Clock: invert every half period
  always #2.5 i_core_clk = ~i_core_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Expected gain factor; channel A has its own 8 and 16 steps
  function automatic logic [4:0] fact(input logic [1:0] c, input logic is_a);
    logic [4:0] t [4];
    if (is_a)
      t = '{5'h01, 5'h02, 5'h08, 5'h10};
    else
      t = '{5'h01, 5'h02, 5'h04, 5'h04};
    return t[c];
  endfunction

  // Write one register word
  task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
    access(1'b1, 1'b0, a, d);
  endtask

  // Read one register word into seen and seen_v
  task automatic reg_read(input logic [6:0] a);
    access(1'b0, 1'b1, a, 16'h0000);
  endtask

  // One host access: strobes stand one cycle, answer taken a cycle later
  task automatic access(input logic w, input logic r, input logic [6:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    req = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge i_core_clk);
    req  = '0;
    seen = rdata;
    seen_v = rvalid;
  endtask

  // Print counts and verdict, then stop
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    i_core_clk = 1'b0;
    i_reset = 1'b1;
    req = '0;
    strap_h = 1'b0;
    strap_l = 1'b0;
    spi = 1'b0;
    smp_in = 24'h000000;
    err_total = 0;
    checks_done = 0;
    repeat (3) @(negedge i_core_clk);
    `CHK("image in reset", 16'h0003, image)
    `CHK("factor A in reset", 5'h10, fa)
    `CHK("factor B in reset", 5'h01, fb)
    @(negedge i_core_clk);
    i_reset = 1'b0;
    // The first edge after release already loads the strap code
    `CHK("image after release", 16'h0003, image)
    @(negedge i_core_clk);
    `CHK("image with straps 00", 16'h2E03, image)
    // register at address zero, other addresses read zero
    access(1'b0, 1'b1, 7'h00, 16'h0000);
    `CHK("rvalid", 1'b1, seen_v)
    `CHK("rdata", 16'h2E03, seen)
    @(negedge i_core_clk);
    `CHK("rvalid drop", 1'b0, rvalid)
    access(1'b1, 1'b0, 7'h01, 16'h0045);
    access(1'b0, 1'b1, 7'h01, 16'h0000);
    `CHK("unmapped rdata", 16'h0000, seen)
    `CHK("unmapped write", 16'h2E03, image)
    // every strap setting reaches field and checksum
    for (int i = 0; i < 4; i++)
    begin
      {strap_h, strap_l} = i[1:0];
      repeat (2) @(negedge i_core_clk);
      `CHK("baud field", codes[i], image[14:8])
      `CHK("checksum baud", codes[i], csum[14:8])
      reg_read(7'h00);
      `CHK("baud read", codes[i], seen[14:8])
    end
    // low strap falls while the high strap holds
    {strap_h, strap_l} = 2'h2;
    repeat (2) @(negedge i_core_clk);
    `CHK("baud after low strap falls", 7'h0B, image[14:8])
    {strap_h, strap_l} = 2'h3;
    spi = 1'b1;
    repeat (2) @(negedge i_core_clk);
    `CHK("baud with SPI", 7'h00, image[14:8])
    `CHK("checksum SPI", 7'h00, csum[14:8])
    spi = 1'b0;
    repeat (2) @(negedge i_core_clk);
    // every gain code; ones written into the baud field
    for (int k = 0; k < 4; k++)
    begin
      // Reserved bits 15 and 7 are written as zero
      wd = {1'b0, 7'h7F, 1'b0, 1'b1, k[1:0], k[1:0], k[1:0]};
      access(1'b1, 1'b0, 7'h00, wd);
      `CHK("image after write", {1'b0, 7'h05, wd[7:0]}, image)
      `CHK("checksum word", {1'b0, 7'h05, wd[7:0]}, csum)
      `CHK("channel B on", 1'b1, adc_on)
      `CHK("gain A field", k[1:0], ga)
      `CHK("factor A", fact(k[1:0], 1'b1), fa)
      `CHK("gain B field", k[1:0], gb)
      `CHK("factor B", fact(k[1:0], 1'b0), fb)
      `CHK("gain U field", k[1:0], gu)
      `CHK("factor U", fact(k[1:0], 1'b0), fu)
    end
    // Read and write together: the read sees the old image
    access(1'b1, 1'b1, 7'h00, 16'h0000);
    `CHK("old image read", 16'h057F, seen)
    `CHK("cleared image", 16'h0500, image)
    // channel B gated by bit 6
    smp_in = 24'hABCDEF;
    @(negedge i_core_clk);
    `CHK("sample off", 24'h000000, smp_out)
    access(1'b1, 1'b0, 7'h00, 16'h0040);
    @(negedge i_core_clk);
    `CHK("sample on", 24'hABCDEF, smp_out)
    smp_in = 24'h123456;
    @(negedge i_core_clk);
    `CHK("sample follows", 24'h123456, smp_out)
    access(1'b1, 1'b0, 7'h00, 16'h0000);
    @(negedge i_core_clk);
    `CHK("sample shut", 24'h000000, smp_out)
    // Second reset in mid-run restores the defaults
    reg_write(7'h00, 16'h0055);
    `CHK("image before reset", 16'h0555, image)
    i_reset = 1'b1;
    repeat (2) @(negedge i_core_clk);
    `CHK("image mid reset", 16'h0003, image)
    `CHK("factor A mid reset", 5'h10, fa)
    i_reset = 1'b0;
    `CHK("image at second release", 16'h0003, image)
    @(negedge i_core_clk);
    `CHK("image after second release", 16'h0503, image)
    @(negedge i_core_clk);
    `CHK("factor A after second release", 5'h10, fa)
    test_done();
  end

  // Watchdog: the tests need about sixty cycles
  initial
  begin
    repeat (2000) @(posedge i_core_clk);
    err_total++;
    test_done();
  end
endmodule
